// >>> logic/can_buf_ctrl.sv
// Notes on behaviour
// R1: Each extended id mask bit set to one includes that id bit in the acceptance compare, zero ignores it.
// R2: Storing a received message sets that buffer's full flag; 32 flags in two 16-bit words, reset zero.
// R3: Full and overflow flags are readable and writing zero to one clears it.
// R4: Storing into a buffer whose full flag is still set sets its overflow flag.
// R5: Each control word serves two buffers, odd one in the upper byte, even one in the lower, same layout.
// R6: The direction bit makes a buffer transmit when one and receive when zero.
// R7: The read-only aborted flag is one after an abort and zero after a successful send.
// R8: The read-only lost arbitration flag is set when the message lost arbitration.
// R9: The read-only transmit error flag is set when a bus error hits that message.
// R10: Software sets the send request and the block clears it once the message is sent.
// R11: Clearing a send request that is still set asks the engine to abort that message.
// R12: With auto remote enabled a matching remote frame sets the send request, else it is untouched.
// R13: The two-bit priority orders pending sends, 11 highest down to 00 lowest.
// R14: Setting the send request clears the aborted, lost arbitration and error flags.
// R15: Message contents live in DMA RAM; this block only tracks buffer numbers.
// R16: Writing one to a full or overflow flag leaves it unchanged.
`timescale 1ns/100ps
module can_buf_ctrl
  import can_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [DW-1:0] reg_rdata,
  input  wire logic [DW-1:0] msg_eid,
  input  wire logic [DW-1:0] flt_eid,
  output logic               eid_match,
  input  wire logic          rx_store_valid,
  input  wire logic [IW-1:0] rx_store_idx,
  output logic               rx_store_ready,
  input  wire logic          rtr_valid,
  input  wire logic [TW-1:0] rtr_idx,
  input  wire logic          tx_done,
  input  wire logic          tx_aborted,
  input  wire logic          tx_lost_arb,
  input  wire logic          tx_bus_err,
  input  wire logic [TW-1:0] tx_evt_idx,
  output logic     [NTX-1:0] tx_pending,
  output logic     [NTX-1:0] abort_req,
  output logic               tx_sel_valid,
  output logic      [TW-1:0] tx_sel_idx
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DW-1:0]         mask_r;
  logic [NBUF-1:0]       full_r;
  logic [NBUF-1:0]       full_nxt;
  logic [NBUF-1:0]       ovf_r;
  logic [NBUF-1:0]       ovf_nxt;
  logic [NTX-1:0]        dir_r;
  logic [NTX-1:0]        dir_nxt;
  logic [NTX-1:0]        abt_r;
  logic [NTX-1:0]        abt_nxt;
  logic [NTX-1:0]        larb_r;
  logic [NTX-1:0]        larb_nxt;
  logic [NTX-1:0]        err_r;
  logic [NTX-1:0]        err_nxt;
  logic [NTX-1:0]        sreq_r;
  logic [NTX-1:0]        sreq_nxt;
  logic [NTX-1:0]        rten_r;
  logic [NTX-1:0]        rten_nxt;
  logic [NTX-1:0]        abort_r;
  logic [NTX-1:0]        abort_nxt;
  logic [NTX-1:0][1:0]   pri_r;
  logic [NTX-1:0][1:0]   pri_nxt;
  logic [DW-1:0]         rdata_r;
  logic                  match_r;
  logic                  sel_valid_r;
  logic [TW-1:0]         sel_idx_r;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire           wr_mask    = reg_wr && (reg_addr == A_MASK);
  wire           wr_full_lo = reg_wr && (reg_addr == A_FULL_LO);
  wire           wr_full_hi = reg_wr && (reg_addr == A_FULL_HI);
  wire           wr_ovf_lo  = reg_wr && (reg_addr == A_OVF_LO);
  wire           wr_ovf_hi  = reg_wr && (reg_addr == A_OVF_HI);
  wire           con_hit    = (reg_addr >= A_CON0) &&
                              (reg_addr <= A_CON_LAST);
  wire [AW-1:0]  con_off    = reg_addr - A_CON0;
  wire [1:0]     con_k      = con_off[1:0];
  wire           flag_wr    = wr_full_lo || wr_full_hi ||
                              wr_ovf_lo || wr_ovf_hi;

  // Software write masks: ones keep a flag, zeros clear it
  wire [NBUF-1:0] full_keep = wr_full_lo ? {{HALF{1'b1}}, reg_wdata} :
                              wr_full_hi ? {reg_wdata, {HALF{1'b1}}} :
                              {NBUF{1'b1}}; // R3 R16
  wire [NBUF-1:0] ovf_keep  = wr_ovf_lo ? {{HALF{1'b1}}, reg_wdata} :
                              wr_ovf_hi ? {reg_wdata, {HALF{1'b1}}} :
                              {NBUF{1'b1}}; // R3 R16

  logic [NTX-1:0]        con_we;
  logic [BYTE_W-1:0]     con_wb   [NTX];
  logic [BYTE_W-1:0]     con_rb   [NTX];
  logic [DW-1:0]         con_word [NTX/2];

  // ----------------------------------------------------------------
  // Buffer pair layout
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NTX; g++)
  begin : g_byte
    assign con_we[g] = reg_wr && con_hit && (con_k == 2'(g / 2)); // R5
    assign con_wb[g] = reg_wdata[(g % 2) * BYTE_W +: BYTE_W];     // R5
    assign con_rb[g] = {dir_r[g], abt_r[g], larb_r[g], err_r[g],
                        sreq_r[g], rten_r[g], pri_r[g]};
  end
  for (genvar g = 0; g < NTX / 2; g++)
  begin : g_word
    assign con_word[g] = {con_rb[2*g+1], con_rb[2*g]}; // R5
  end

  wire [DW-1:0] rd_val =
    (reg_addr == A_MASK)    ? mask_r :
    (reg_addr == A_FULL_LO) ? full_r[HALF-1:0] :
    (reg_addr == A_FULL_HI) ? full_r[NBUF-1:HALF] :
    (reg_addr == A_OVF_LO)  ? ovf_r[HALF-1:0] :
    (reg_addr == A_OVF_HI)  ? ovf_r[NBUF-1:HALF] :
    con_hit                 ? con_word[con_k] : '0;

  // ----------------------------------------------------------------
  // Receive store path
  // ----------------------------------------------------------------
  // Only buffer numbers travel here; payload goes straight to RAM
  fifo_if #(.W(IW)) rxq (); // R15

  assign rxq.push_valid = rx_store_valid;
  assign rxq.push_data  = rx_store_idx;
  // Drain stalls while software edits flags, so the queue can fill
  assign rxq.pop_ready  = !flag_wr;
  assign rx_store_ready = rxq.push_ready && clk_en;

  fifo_buf #(.W(IW), .D(FIFO_DEPTH)) u_rxq
  (
    .clk    (clk),
    .rstn   (rstn),
    .clk_en (clk_en),
    .f      (rxq)
  );

  wire           pop_fire = rxq.pop_valid && rxq.pop_ready && clk_en;
  wire [IW-1:0]  pop_idx  = rxq.pop_data;
  // A buffer set to transmit takes no received message
  wire           pop_tx   = (pop_idx < IW'(NTX)) &&
                            dir_r[pop_idx[TW-1:0]]; // R6
  wire           store_ok = pop_fire && !pop_tx;
  wire [NBUF-1:0] pop_onehot = NBUF'(1) << pop_idx;

  always_comb
  begin
    full_nxt = full_r & full_keep;
    ovf_nxt  = ovf_r & ovf_keep;
    if (store_ok)
    begin
      // Store beats a clear in the same cycle
      if (full_r[pop_idx])
        ovf_nxt = ovf_nxt | pop_onehot; // R4
      full_nxt = full_nxt | pop_onehot; // R2
    end
  end

  // ----------------------------------------------------------------
  // Transmit control per buffer
  // ----------------------------------------------------------------
  wire rtr_fire = rtr_valid && clk_en;

  always_comb
  begin
    logic hit_evt;
    logic rise;
    hit_evt = 1'b0;
    rise    = 1'b0;
    for (int i = 0; i < NTX; i++)
    begin
      hit_evt     = (tx_evt_idx == TW'(i));
      dir_nxt[i]  = con_we[i] ? con_wb[i][B_DIR] : dir_r[i]; // R6
      rten_nxt[i] = con_we[i] ? con_wb[i][B_RTR] : rten_r[i];
      pri_nxt[i]  = con_we[i] ? con_wb[i][B_PRI +: 2] : pri_r[i];
      sreq_nxt[i] = con_we[i] ? con_wb[i][B_REQ] :
                    (tx_done && hit_evt) ? 1'b0 : sreq_r[i]; // R10
      if (rtr_fire && (rtr_idx == TW'(i)) && rten_r[i])
        sreq_nxt[i] = 1'b1; // R12
      rise = sreq_nxt[i] && !sreq_r[i];
      // Event flags are cleared by a fresh request, set by events
      abt_nxt[i]  = rise ? 1'b0 : abt_r[i]; // R14
      larb_nxt[i] = (rise ? 1'b0 : larb_r[i]) ||
                    (tx_lost_arb && hit_evt); // R8 R14
      err_nxt[i]  = (rise ? 1'b0 : err_r[i]) ||
                    (tx_bus_err && hit_evt); // R9 R14
      if (tx_done && hit_evt)
        abt_nxt[i] = 1'b0; // R7
      if (tx_aborted && hit_evt)
        abt_nxt[i] = 1'b1; // R7
      abort_nxt[i] = abort_r[i];
      if ((tx_done || tx_aborted) && hit_evt)
        abort_nxt[i] = 1'b0;
      if (con_we[i] && !con_wb[i][B_REQ] && sreq_r[i])
        abort_nxt[i] = 1'b1; // R11
    end
  end

  // ----------------------------------------------------------------
  // Priority pick
  // ----------------------------------------------------------------
  assign tx_pending = sreq_r & dir_r; // R6
  assign abort_req  = abort_r;        // R11

  logic          sel_v;
  logic [TW-1:0] sel_i;
  logic [1:0]    sel_p;

  // Ties go to the lower buffer number
  always_comb
  begin
    sel_v = 1'b0;
    sel_i = '0;
    sel_p = '0;
    for (int i = 0; i < NTX; i++)
    begin
      if (tx_pending[i] && (!sel_v || (pri_r[i] > sel_p)))
      begin
        sel_v = 1'b1;
        sel_i = TW'(i);
        sel_p = pri_r[i]; // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Acceptance compare
  // ----------------------------------------------------------------
  wire match_now = (((msg_eid ^ flt_eid) & mask_r) == '0); // R1

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mask_r  <= MASK_RST;
      full_r  <= FLAG_RST;
      ovf_r   <= FLAG_RST;
      rdata_r <= '0;
      match_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_mask)
        mask_r <= reg_wdata;
      full_r  <= full_nxt;
      ovf_r   <= ovf_nxt;
      rdata_r <= reg_rd ? rd_val : '0;
      match_r <= match_now;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_r       <= CON_RST;
      abt_r       <= CON_RST;
      larb_r      <= CON_RST;
      err_r       <= CON_RST;
      sreq_r      <= CON_RST;
      rten_r      <= CON_RST;
      abort_r     <= CON_RST;
      pri_r       <= '0;
      sel_valid_r <= 1'b0;
      sel_idx_r   <= '0;
    end
    else if (clk_en)
    begin
      dir_r       <= dir_nxt;
      abt_r       <= abt_nxt;
      larb_r      <= larb_nxt;
      err_r       <= err_nxt;
      sreq_r      <= sreq_nxt;
      rten_r      <= rten_nxt;
      abort_r     <= abort_nxt;
      pri_r       <= pri_nxt;
      sel_valid_r <= sel_v;
      sel_idx_r   <= sel_i;
    end
  end

  assign reg_rdata    = rdata_r;
  assign eid_match    = match_r;
  assign tx_sel_valid = sel_valid_r;
  assign tx_sel_idx   = sel_idx_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic higher_exists;
  always_comb
  begin
    higher_exists = 1'b0;
    for (int i = 0; i < NTX; i++)
      if (tx_pending[i] && ((pri_r[i] > pri_r[sel_i]) ||
          ((pri_r[i] == pri_r[sel_i]) && (TW'(i) < sel_i))))
        higher_exists = 1'b1;
  end

  wire evt0 = (tx_evt_idx == '0) &&
              (tx_aborted || tx_lost_arb || tx_bus_err);

  full_set_a: assert property ( // R2
    store_ok |=> full_r[$past(pop_idx)])
    else $error("full flag not set on store");
  ovf_set_a: assert property ( // R4
    store_ok && full_r[pop_idx] |=> ovf_r[$past(pop_idx)])
    else $error("overflow flag not set on store to full buffer");
  flag_clear_a: assert property ( // R3
    clk_en && wr_full_lo && !store_ok |=>
      full_r[HALF-1:0] == ($past(full_r[HALF-1:0]) & $past(reg_wdata)))
    else $error("full flag write did not clear zeros only");
  done_clear_a: assert property ( // R10
    clk_en && tx_done && !con_we[tx_evt_idx] && !rtr_fire
      |=> !sreq_r[$past(tx_evt_idx)])
    else $error("send request not cleared after success");
  abort_req_a: assert property ( // R11
    clk_en && con_we[0] && !con_wb[0][B_REQ] && sreq_r[0] &&
      !(rtr_fire && rtr_idx == '0) |=> abort_req[0] && !sreq_r[0])
    else $error("clearing a live request did not raise abort");
  rtr_set_a: assert property ( // R12
    rtr_fire && rten_r[rtr_idx] |=> sreq_r[$past(rtr_idx)])
    else $error("remote frame did not set send request");
  flags_clear_a: assert property ( // R14
    $rose(sreq_r[0]) && !$past(evt0) |-> !abt_r[0] && !larb_r[0]
      && !err_r[0])
    else $error("event flags survived a new send request");
  prio_pick_a: assert property ( // R13
    sel_v |-> !higher_exists && tx_pending[sel_i])
    else $error("priority pick is not the highest pending buffer");
  mask_match_a: assert property ( // R1
    clk_en |=> eid_match == ((($past(msg_eid) ^ $past(flt_eid)) &
      $past(mask_r)) == '0))
    else $error("extended id compare ignores the mask");
  read_once_a: assert property ( // R3
    clk_en && !reg_rd |=> reg_rdata == '0)
    else $error("read data held beyond its cycle");

  ovf_seen_c:   cover property (store_ok && full_r[pop_idx]);
  abort_seen_c: cover property (abort_req[0] ##[1:20] tx_aborted);
  rtr_seen_c:   cover property (rtr_fire && rten_r[rtr_idx]);
  queue_full_c: cover property (!rxq.push_ready);

endmodule

// >>> logic/can_pkg.sv
package can_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DW         = 16;
  localparam int AW         = 4;
  localparam int NBUF       = 32;
  localparam int NTX        = 8;
  localparam int IW         = 5;
  localparam int TW         = 3;
  localparam int HALF       = 16;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_MASK     = 4'h0;
  localparam logic [AW-1:0] A_FULL_LO  = 4'h1;
  localparam logic [AW-1:0] A_FULL_HI  = 4'h2;
  localparam logic [AW-1:0] A_OVF_LO   = 4'h3;
  localparam logic [AW-1:0] A_OVF_HI   = 4'h4;
  localparam logic [AW-1:0] A_CON0     = 4'h5;
  localparam logic [AW-1:0] A_CON_LAST = 4'h8;

  // ----------------------------------------------------------------
  // Control byte layout, same in both halves
  // ----------------------------------------------------------------
  localparam int B_DIR  = 7;
  localparam int B_ABT  = 6;
  localparam int B_LARB = 5;
  localparam int B_ERR  = 4;
  localparam int B_REQ  = 3;
  localparam int B_RTR  = 2;
  localparam int B_PRI  = 0;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DW-1:0]   MASK_RST = 16'h0000;
  localparam logic [NBUF-1:0] FLAG_RST = 32'h0000_0000;
  localparam logic [NTX-1:0]  CON_RST  = 8'h00;

endpackage

// >>> logic/fifo_if.sv
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 5);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport store
  (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user
  (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data
  );
endinterface

// >>> logic/fifo_buf.sv
`timescale 1ns/100ps
module fifo_buf #(
  parameter int W = 5,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  fifo_if.store    f
);
  localparam int PW = $clog2(D);
  localparam logic [PW:0]   CNT_FULL = (PW+1)'(D);
  localparam logic [PW-1:0] PTR_LAST = PW'(D-1);

  logic [W-1:0]  mem_r [D];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  wire           push_fire = f.push_valid && f.push_ready && clk_en;
  wire           pop_fire  = f.pop_valid && f.pop_ready && clk_en;

  assign f.push_ready = (cnt_r != CNT_FULL);
  assign f.pop_valid  = (cnt_r != '0);
  assign f.pop_data   = mem_r[rp_r];

  always_ff @(posedge clk)
  begin
    if (push_fire)
      mem_r[wp_r] <= f.push_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push_fire)
        wp_r <= (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
      if (pop_fire)
        rp_r <= (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(push_fire) - (PW+1)'(pop_fire);
    end
  end

  fifo_count_a: assert property (@(posedge clk) disable iff (!rstn)
    push_fire && !pop_fire |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule

// >>> tb/engine_model.sv
`timescale 1ns/100ps
module engine_model
  import can_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rx_store_ready,
  output logic               rx_store_valid,
  output logic      [IW-1:0] rx_store_idx,
  output logic               rtr_valid,
  output logic      [TW-1:0] rtr_idx,
  output logic         [3:0] evt,
  output logic      [TW-1:0] tx_evt_idx
);
  // ---------------------------------------------------------------
  // Protocol engine stand-in
  // ---------------------------------------------------------------
  // Released indices show the inverse, so a stale index never matches
  initial
  begin
    rx_store_valid = 1'b0;
    rx_store_idx   = 5'h1F;
    rtr_valid      = 1'b0;
    rtr_idx        = 3'h7;
    evt            = 4'h0;
    tx_evt_idx     = 3'h7;
  end
  // Stores stay offered until taken; ready sampled mid-cycle
  task automatic push(input logic [IW-1:0] first, input int n);
    int   got;
    int   tries;
    logic ok;
    got   = 0;
    tries = 0;
    @(posedge clk);
    rx_store_valid <= 1'b1;
    rx_store_idx   <= first;
    while (got < n && tries < 100)
    begin
      @(negedge clk);
      ok = rx_store_ready;
      @(posedge clk);
      tries++;
      if (ok)
        got++;
      rx_store_valid <= (got < n);
      rx_store_idx   <= (got < n) ? first + IW'(got) : ~rx_store_idx;
    end
  endtask
  // Kind is {done, aborted, lost arbitration, bus error}
  task automatic tx_event(input logic [3:0]    kind,
                          input logic [TW-1:0] idx);
    @(posedge clk);
    evt        <= kind;
    tx_evt_idx <= idx;
    @(posedge clk);
    evt        <= 4'h0;
    tx_evt_idx <= ~idx;
  endtask
  task automatic remote(input logic [TW-1:0] idx);
    @(posedge clk);
    rtr_valid <= 1'b1;
    rtr_idx   <= idx;
    @(posedge clk);
    rtr_valid <= 1'b0;
    rtr_idx   <= ~idx;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import can_pkg::*;
;
  logic           clk;
  logic           rstn;
  logic           clk_en;
  logic           reg_wr;
  logic           reg_rd;
  logic [AW-1:0]  reg_addr;
  logic [DW-1:0]  reg_wdata;
  logic [DW-1:0]  reg_rdata;
  logic [DW-1:0]  msg_eid;
  logic [DW-1:0]  flt_eid;
  logic           eid_match;
  logic           rx_store_valid;
  logic           rx_store_ready;
  logic [IW-1:0]  rx_store_idx;
  logic           rtr_valid;
  logic [TW-1:0]  rtr_idx;
  logic [3:0]     evt;
  logic [TW-1:0]  tx_evt_idx;
  logic [NTX-1:0] tx_pending;
  logic [NTX-1:0] abort_req;
  logic           tx_sel_valid;
  logic [TW-1:0]  tx_sel_idx;
  int             n_errors = 0;
  int             comparisons = 0;
  can_buf_ctrl dut_u
  (
    .clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .msg_eid, .flt_eid, .eid_match, .rx_store_valid,
    .rx_store_idx, .rx_store_ready, .rtr_valid, .rtr_idx,
    .tx_done(evt[3]), .tx_aborted(evt[2]), .tx_lost_arb(evt[1]),
    .tx_bus_err(evt[0]), .tx_evt_idx, .tx_pending, .abort_req,
    .tx_sel_valid, .tx_sel_idx
  );
  engine_model eng_u
  (
    .clk, .rx_store_ready, .rx_store_valid, .rx_store_idx, .rtr_valid,
    .rtr_idx, .evt, .tx_evt_idx
  );
  always #10 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Flags land a few cycles after a store, so reads retry a bounded time
  task automatic poll(input string what, input logic [AW-1:0] a,
                      input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    for (int i = 0; i < 10; i++)
    begin
      rd(a, v);
      if (v === exp)
        break;
    end
    check(what, v, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    wr(4'hF, 16'hFFFF);
    for (int a = 0; a < 16; a++)
      poll("reset value", 4'(a), 16'h0000);
  endtask
  task automatic t_mask();
    wr(A_MASK, 16'h00FF);
    poll("mask", A_MASK, 16'h00FF);
    @(posedge clk);
    msg_eid <= 16'h1234;
    flt_eid <= 16'hEE34;
    settle();
    check("masked upper", {15'h0, eid_match}, 16'h0001);
    @(posedge clk);
    flt_eid <= 16'h1235;
    settle();
    check("compared lower", {15'h0, eid_match}, 16'h0000);
  endtask
  // Enable low must hold every register, writes included
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    wr(A_MASK, 16'h5A5A);
    @(posedge clk);
    clk_en <= 1'b1;
    poll("frozen mask", A_MASK, 16'h00FF);
  endtask
  // Back-to-back flag writes hold the queue so it fills up
  task automatic t_fill();
    fork
      begin
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= A_FULL_LO;
        reg_wdata <= 16'hFFFF;
        repeat (20) @(posedge clk);
        reg_wr    <= 1'b0;
      end
      begin
        eng_u.push(5'h10, FIFO_DEPTH);
        @(negedge clk);
        check("queue full", {15'h0, rx_store_ready}, 16'h0000);
      end
    join
    poll("drained", A_FULL_HI, 16'h00FF);
    poll("ones kept", A_FULL_LO, 16'h0000);
  endtask
  task automatic t_rx();
    eng_u.push(5'h03, 1);
    poll("full set", A_FULL_LO, 16'h0008);
    eng_u.push(5'h03, 1);
    poll("overflow low", A_OVF_LO, 16'h0008);
    eng_u.push(5'h14, 1);
    poll("overflow high", A_OVF_HI, 16'h0010);
    wr(A_OVF_LO, 16'hFFFF);
    poll("overflow kept", A_OVF_LO, 16'h0008);
    wr(A_FULL_LO, 16'hFFF7);
    poll("full cleared", A_FULL_LO, 16'h0000);
    wr(A_OVF_LO, 16'h0000);
    poll("overflow cleared", A_OVF_LO, 16'h0000);
  endtask
  task automatic t_tx();
    wr(A_CON0, 16'h8B88);
    settle();
    check("pending", {8'h00, tx_pending}, 16'h0003);
    check("first pick", {13'h0, tx_sel_idx}, 16'h0001);
    eng_u.tx_event(4'h8, 3'h1);
    poll("sent", A_CON0, 16'h8388);
    eng_u.tx_event(4'h3, 3'h0);
    poll("arb and error", A_CON0, 16'h83B8);
    wr(A_CON0, 16'h8380);
    settle();
    check("abort asked", {8'h00, abort_req}, 16'h0001);
    eng_u.tx_event(4'h4, 3'h0);
    poll("aborted", A_CON0, 16'h83F0);
    check("abort ended", {8'h00, abort_req}, 16'h0000);
    wr(A_CON0, 16'h83F8);
    poll("flags cleared", A_CON0, 16'h8388);
    eng_u.tx_event(4'h8, 3'h0);
    poll("completed", A_CON0, 16'h8380);
    wr(A_CON0 + 4'h1, 16'h8084);
    eng_u.remote(3'h2);
    eng_u.remote(3'h3);
    poll("remote reply", A_CON0 + 4'h1, 16'h808C);
  endtask
  // Priorities out of index order, so neither index order passes
  task automatic t_prio();
    int order [4] = '{4, 6, 5, 7};
    wr(A_CON0 + 4'h1, 16'h0000);
    wr(A_CON0 + 4'h2, 16'h898B);
    wr(A_CON_LAST, 16'h888A);
    for (int k = 0; k < 4; k++)
    begin
      settle();
      check("pick order", {13'h0, tx_sel_idx}, 16'(order[k]));
      eng_u.tx_event(4'h8, 3'(order[k]));
    end
    settle();
    check("none pending", {15'h0, tx_sel_valid}, 16'h0000);
  endtask
  initial
  begin
    clk       = 1'b0;
    rstn      = 1'b0;
    clk_en    = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    msg_eid   = 16'h0000;
    flt_eid   = 16'h0000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mask();
    t_freeze();
    t_fill();
    t_rx();
    t_tx();
    t_prio();
    close_out();
  end
  // Whole run needs a few thousand cycles at most
  initial
  begin
    #(20 * 20000);
    n_errors++;
    close_out();
  end
endmodule
